// ### verilog/rst_seq_defs.svh
// Purpose: Constants for the reset and initial state controller
// Assumes: 125 MHz master clock
// Notes:   Offsets, field values and timing counts only
`ifndef RST_SEQ_DEFS_SVH
`define RST_SEQ_DEFS_SVH

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define MAP_RESET          8'h01
`define TIMER_COUNT_RESET  16'h0000
`define COMPARE_RESET      16'hffff
`define PSEL_RESET         4'h5
`define PORTC_DIR_RESET    8'h00
`define PORTA_DIR_RESET    8'h78
`define PORTB_EXPANDED     8'hff
`define PORTB_SINGLE       8'h00
`define HANDSHAKE_PINS     18

// ------------------------------------------------------------
// Vectors
// ------------------------------------------------------------
`define VEC_NORMAL_HI      8'hff
`define VEC_SPECIAL_HI     8'hbf
`define VEC_EXT_LO         8'hfe
`define VEC_CLKMON_LO      8'hfc
`define VEC_WDOG_LO        8'hfa

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS      8
`define PIN_DRIVE_NS       32
`define PIN_DRIVE_CYC      ((`PIN_DRIVE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DIV_WIDTH          2
`define FETCH_CYCLES       3

`endif

// ### verilog/rst_seq_pkg.sv
// Purpose: Types for the reset and initial state controller
// Assumes: Constants come from rst_seq_defs.svh
// Notes:   Types only
package rst_seq_pkg;

    typedef enum logic [2:0] {
        ST_HOLD   = 3'b000,
        ST_DRIVE  = 3'b001,
        ST_FETCH  = 3'b010,
        ST_RUN    = 3'b011
    } seq_state_t;

    typedef enum logic [1:0] {
        CAUSE_EXT    = 2'b00,
        CAUSE_CLKMON = 2'b01,
        CAUSE_WDOG   = 2'b10
    } cause_t;

    typedef struct packed {
        logic boot_rom_enable_bit;
        logic special_mode_bit;
        logic mode_a_latched_bit;
        logic vector_relocate_bit;
    } mode_bits_t;

    typedef struct packed {
        logic x_mask;
        logic i_mask;
        logic stop_disable;
    } ccr_flags_t;

    typedef struct packed {
        logic strobe_flag;
        logic strobe_interrupt_enable;
        logic handshake_select;
        logic port_c_open_drain_select;
        logic strobe_edge_select;
    } parallel_control_register_t;

    typedef struct packed {
        logic [15:0] count;
        logic [1:0]  prescale;
        logic [15:0] compare_val;
        logic [7:0]  compare_one_pin_mask;
        logic        compare_pin_enable;
        logic        capture_enable;
        logic        overflow_flag;
        logic [7:0]  function_flags;
        logic [8:0]  irq_enables;
    } timer_init_t;

    typedef struct packed {
        logic       irq_mask;
        logic       tx_enable;
        logic       rx_enable;
        logic       nine_bit;
        logic       send_break;
        logic       rx_wakeup;
        logic       transmit_buffer_empty_flag;
        logic       transmit_done_flag;
        logic       receive_full_flag;
        logic       idle_flag;
        logic       overrun_flag;
        logic       framing_error_flag;
    } serial_init_t;

    typedef struct packed {
        logic       periodic_flag;
        logic       periodic_mask;
        logic [1:0] periodic_rate;
        logic       watchdog_enable;
        logic [1:0] watchdog_rate;
        logic       sync_port_enable;
        logic       conv_done_flag;
        logic       converter_power_up_bit;
        logic       eeprom_prog_enable;
        logic [3:0] priority_select;
        logic       irq_edge_mode;
        logic       stop_recovery_delay_enable;
        logic       clock_watch_enable;
    } misc_init_t;

endpackage

// ### verilog/clk_divider.sv
// Purpose: Oscillator divider issuing a one-cycle bus rate enable
// Assumes: Runs on mclk_i; the srst_i level steers it
// Notes:   Cleared by a reset level even before the sequencer moves
`timescale 1ns/1ns
`include "rst_seq_defs.svh"

module clk_divider (
    input  wire logic mclk_i,
    input  wire logic clr_i,
    output logic      tick_o
);

    typedef struct packed {
        logic [`DIV_WIDTH-1:0] cnt;
        logic                  tick;
    } div_state_t;

    div_state_t s_q;
    div_state_t s_d;

    // Next divider state; a clear restarts the count so the oscillator
    // phase begins from zero
    always_comb begin
        s_d = s_q;
        if (clr_i) begin
            s_d.cnt  = '0;
            s_d.tick = 1'b0;
        end else begin
            s_d.cnt  = s_q.cnt + `DIV_WIDTH'(1);
            s_d.tick = (s_q.cnt == {`DIV_WIDTH{1'b1}});
        end
    end

    // Divider register
    always_ff @(posedge mclk_i) begin
        s_q <= s_d;
    end

    assign tick_o = s_q.tick;

endmodule

// ### verilog/reset_initial_state_control.sv
// Purpose: Forces the controller into its start state on any reset
// Assumes: reset_n_pin_i and mode pins arrive asynchronously
// Notes:   Outputs registered except the constant pin and port A levels; state is a single packed struct
//
// How it works
// - Fetch vector FFFE/BFFE within three cycles
// - Set X, I and stop-disable flags
// - Memory map register loads 01
// - ROM and EEPROM enables kept through reset
// - Single-chip clears strobe and handshake bits
// - Strobe edge select set for rising
// - Port directions and levels at defaults
// - Port B ones expanded, zeros single-chip
// - Expanded mode dedicates handshake pins
// - Timer count zero, compares FFFF
// - Timer masks, flags and enables cleared
// - Periodic interrupt flag, mask, rate cleared
// - Watchdog per disable bit, shortest timeout
// - Serial port interrupts, enables, format reset
// - Transmit flags set, receive flags cleared
// - Synchronous serial port disabled
// - Converter done flag and power cleared
// - EEPROM program off, priority 0101, level IRQ
// - Mode pins latched at reset release
// - Stop delay set, clock watch cleared
// - Any cause resets all but the fetch address and synchronisers, drives pin low
// - Clocked sequence; divider clear skips the synchroniser
// - Mode pins decode into four modes
// - Per-cause vector, BF in special modes
`timescale 1ns/1ns
`include "rst_seq_defs.svh"

module reset_initial_state_control (
    input  wire logic                     mclk_i,
    input  wire logic                     srst_i,
    input  wire logic                     reset_n_pin_i,
    input  wire logic                     mode_select_pin_a_i,
    input  wire logic                     mode_select_pin_b_i,
    input  wire logic                     clkmon_fail_i,
    input  wire logic                     wdog_timeout_i,
    input  wire logic                     rom_enable_nv_i,
    input  wire logic                     eeprom_enable_nv_i,
    input  wire logic                     watchdog_disable_bit_i,
    output logic                          reset_n_pin_o,
    output logic                          reset_n_pin_oe_o,
    output logic                          cpu_reset_o,
    output logic [15:0]                   fetch_addr_o,
    output logic                          fetch_valid_o,
    output logic                          cpu_start_o,
    output rst_seq_pkg::ccr_flags_t       condition_code_register_o,
    output logic [7:0]                    map_reg_o,
    output logic                          rom_enable_o,
    output logic                          eeprom_enable_o,
    output rst_seq_pkg::parallel_control_register_t            parallel_control_register_o,
    output logic [7:0]                    port_c_direction_register_o,
    output logic [7:0]                    port_a_dir_o,
    output logic [7:0]                    port_a_out_o,
    output logic [7:0]                    port_b_out_o,
    output logic [5:0]                    port_d_dir_o,
    output logic                          handshake_bus_o,
    output rst_seq_pkg::timer_init_t      timer_o,
    output rst_seq_pkg::serial_init_t     serial_o,
    output rst_seq_pkg::misc_init_t       misc_o,
    output rst_seq_pkg::mode_bits_t       priority_register_o,
    output logic                          div_tick_o
);

    // ------------------------------------------------------------
    // State record
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0]                 rst_sync;
        logic [1:0]                 mode_select_pin_a_sync;
        logic [1:0]                 mode_select_pin_b_sync;
        logic [1:0]                 cmon_sync;
        logic [1:0]                 wdog_sync;
        rst_seq_pkg::seq_state_t    st;
        rst_seq_pkg::cause_t        cause;
        logic [2:0]                 cnt;
        logic                       pin_oe;
        logic                       cpu_rst;
        logic [15:0]                addr;
        logic                       fvalid;
        logic                       start;
        rst_seq_pkg::ccr_flags_t    condition_code_register;
        logic [7:0]                 map;
        logic                       rom_en;
        logic                       ee_en;
        rst_seq_pkg::parallel_control_register_t         parallel_control_register;
        logic [7:0]                 port_c_direction_register;
        logic [7:0]                 pa_dir;
        logic [7:0]                 pb_out;
        logic [5:0]                 pd_dir;
        logic                       hs_bus;
        rst_seq_pkg::timer_init_t   tmr;
        rst_seq_pkg::serial_init_t  ser;
        rst_seq_pkg::misc_init_t    misc;
        rst_seq_pkg::mode_bits_t    mode;
    } ctl_state_t;

    ctl_state_t s_q;
    ctl_state_t s_d;
    logic       div_tick;
    logic       any_rst;
    logic       pin_rst;

    // Mode pin decode, used at latch time only; port B reads pin A directly
    function automatic rst_seq_pkg::mode_bits_t decode_mode(
        input logic b,
        input logic a
    );
        rst_seq_pkg::mode_bits_t m;
        m.boot_rom_enable_bit = ~b & ~a;
        m.special_mode_bit    = ~b;
        m.mode_a_latched_bit  = a;
        m.vector_relocate_bit = ~b;
        return m;
    endfunction

    // Vector address from cause and mode
    function automatic logic [15:0] vector_of(
        input rst_seq_pkg::cause_t c,
        input logic                special
    );
        logic [7:0] hi;
        logic [7:0] lo;
        hi = special ? `VEC_SPECIAL_HI : `VEC_NORMAL_HI;
        unique case (c)
            rst_seq_pkg::CAUSE_CLKMON: lo = `VEC_CLKMON_LO;
            rst_seq_pkg::CAUSE_WDOG:   lo = `VEC_WDOG_LO;
            default:                   lo = `VEC_EXT_LO;
        endcase
        return {hi, lo};
    endfunction

    // ------------------------------------------------------------
    // Oscillator divider
    // ------------------------------------------------------------
    // srst clears it directly: no synchroniser wait, so the oscillator
    // restarts even before the sequence advances
    clk_divider u_div (
        .mclk_i (mclk_i),
        .clr_i  (srst_i),
        .tick_o (div_tick)
    );

    // Pin low counts as a request only once we have let go of it; during
    // hold and drive our own pull-down echoes back and would lock us up
    assign pin_rst = ~s_q.rst_sync[1]
                   & (s_q.st != rst_seq_pkg::ST_HOLD)
                   & (s_q.st != rst_seq_pkg::ST_DRIVE);

    assign any_rst = srst_i | pin_rst | s_q.cmon_sync[1]
                   | s_q.wdog_sync[1];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // Two-stage synchronisers; only stage 1 is read elsewhere
        s_d.rst_sync  = {s_q.rst_sync[0], reset_n_pin_i};
        s_d.mode_select_pin_a_sync = {s_q.mode_select_pin_a_sync[0], mode_select_pin_a_i};
        s_d.mode_select_pin_b_sync = {s_q.mode_select_pin_b_sync[0], mode_select_pin_b_i};
        s_d.cmon_sync = {s_q.cmon_sync[0], clkmon_fail_i};
        s_d.wdog_sync = {s_q.wdog_sync[0], wdog_timeout_i};
        s_d.start     = 1'b0;
        s_d.fvalid    = 1'b0;

        if (any_rst) begin
            // Any cause resets the whole state except the fetch address and the synchronisers
            s_d.st      = rst_seq_pkg::ST_HOLD;
            s_d.cpu_rst = 1'b1;
            s_d.cnt     = '0;
            s_d.pin_oe  = 1'b1;
            if (s_q.wdog_sync[1])
                s_d.cause = rst_seq_pkg::CAUSE_WDOG;
            else if (s_q.cmon_sync[1])
                s_d.cause = rst_seq_pkg::CAUSE_CLKMON;
            else
                s_d.cause = rst_seq_pkg::CAUSE_EXT;
            s_d.condition_code_register     = '{x_mask: 1'b1, i_mask: 1'b1,
                            stop_disable: 1'b1};
            s_d.map     = `MAP_RESET;
            s_d.rom_en  = rom_enable_nv_i;
            s_d.ee_en   = eeprom_enable_nv_i;
            s_d.mode    = decode_mode(s_q.mode_select_pin_b_sync[1],
                                      s_q.mode_select_pin_a_sync[1]);
            // Strobe and handshake bits cleared, edge rising
            s_d.parallel_control_register    = '{strobe_flag: 1'b0,
                            strobe_interrupt_enable: 1'b0,
                            handshake_select: 1'b0,
                            port_c_open_drain_select: 1'b0,
                            strobe_edge_select: 1'b1};
            s_d.port_c_direction_register    = `PORTC_DIR_RESET;
            s_d.pa_dir  = `PORTA_DIR_RESET;
            s_d.pd_dir  = '0;
            s_d.pb_out  = s_q.mode_select_pin_a_sync[1] ? `PORTB_EXPANDED
                                           : `PORTB_SINGLE;
            s_d.hs_bus  = s_q.mode_select_pin_a_sync[1];
            s_d.tmr.count       = `TIMER_COUNT_RESET;
            s_d.tmr.prescale    = '0;
            s_d.tmr.compare_val = `COMPARE_RESET;
            s_d.tmr.compare_one_pin_mask = '0;
            s_d.tmr.compare_pin_enable   = 1'b0;
            s_d.tmr.capture_enable       = 1'b0;
            s_d.tmr.overflow_flag        = 1'b0;
            s_d.tmr.function_flags       = '0;
            s_d.tmr.irq_enables          = '0;
            s_d.ser = '{irq_mask: 1'b1, tx_enable: 1'b0,
                        rx_enable: 1'b0, nine_bit: 1'b0,
                        send_break: 1'b0, rx_wakeup: 1'b0,
                        transmit_buffer_empty_flag: 1'b1,
                        transmit_done_flag: 1'b1,
                        receive_full_flag: 1'b0, idle_flag: 1'b0,
                        overrun_flag: 1'b0,
                        framing_error_flag: 1'b0};
            s_d.misc.periodic_flag  = 1'b0;
            s_d.misc.periodic_mask  = 1'b0;
            s_d.misc.periodic_rate  = '0;
            s_d.misc.watchdog_enable = ~watchdog_disable_bit_i;
            s_d.misc.watchdog_rate  = '0;
            s_d.misc.sync_port_enable = 1'b0;
            s_d.misc.conv_done_flag   = 1'b0;
            s_d.misc.converter_power_up_bit = 1'b0;
            s_d.misc.eeprom_prog_enable = 1'b0;
            s_d.misc.priority_select  = `PSEL_RESET;
            s_d.misc.irq_edge_mode    = 1'b0;
            s_d.misc.stop_recovery_delay_enable = 1'b1;
            s_d.misc.clock_watch_enable = 1'b0;
        end else begin
            // Only the pin drive count steps on bus-rate ticks, so no clock means
            // no progress past the drive step
            unique case (s_q.st)
                rst_seq_pkg::ST_HOLD: begin
                    s_d.st  = rst_seq_pkg::ST_DRIVE;
                    s_d.cnt = '0;
                end
                rst_seq_pkg::ST_DRIVE: begin
                    // Pin stays low a short while after release
                    if (s_q.pin_oe) begin
                        if (div_tick) begin
                            s_d.cnt = s_q.cnt + 3'd1;
                            if (s_q.cnt == 3'(`PIN_DRIVE_CYC - 1)) begin
                                s_d.pin_oe = 1'b0;
                                s_d.cnt    = '0;
                            end
                        end
                    end else if (s_q.rst_sync[1]) begin
                        // Pin back high: nobody else holds it
                        s_d.cpu_rst = 1'b0;
                        s_d.st      = rst_seq_pkg::ST_FETCH;
                    end
                end
                rst_seq_pkg::ST_FETCH: begin
                    s_d.addr   = vector_of(s_q.cause,
                                   s_q.mode.vector_relocate_bit);
                    s_d.fvalid = 1'b1;
                    s_d.cnt    = s_q.cnt + 3'd1;
                    if (s_q.cnt == 3'(`FETCH_CYCLES - 1)) begin
                        s_d.start = 1'b1;
                        s_d.st    = rst_seq_pkg::ST_RUN;
                    end
                end
                rst_seq_pkg::ST_RUN: begin
                    s_d.st = rst_seq_pkg::ST_RUN;
                end
                default: begin
                    s_d.st = rst_seq_pkg::ST_HOLD;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        s_q <= s_d;
    end

    // ------------------------------------------------------------
    // Outputs from s_q, except the divider tick and the constant pin and port A levels
    // ------------------------------------------------------------
    assign reset_n_pin_o    = 1'b0;   // Open drain: only ever pulls low
    assign reset_n_pin_oe_o = s_q.pin_oe;
    assign cpu_reset_o      = s_q.cpu_rst;
    assign fetch_addr_o     = s_q.addr;
    assign fetch_valid_o    = s_q.fvalid;
    assign cpu_start_o      = s_q.start;
    assign condition_code_register_o   = s_q.condition_code_register;
    assign map_reg_o        = s_q.map;
    assign rom_enable_o     = s_q.rom_en;
    assign eeprom_enable_o  = s_q.ee_en;
    assign parallel_control_register_o = s_q.parallel_control_register;
    assign port_c_direction_register_o = s_q.port_c_direction_register;
    assign port_a_dir_o     = s_q.pa_dir;
    assign port_a_out_o     = 8'h00;
    assign port_b_out_o     = s_q.pb_out;
    assign port_d_dir_o     = s_q.pd_dir;
    assign handshake_bus_o  = s_q.hs_bus;
    assign timer_o          = s_q.tmr;
    assign serial_o         = s_q.ser;
    assign misc_o           = s_q.misc;
    assign priority_register_o = s_q.mode;
    assign div_tick_o       = div_tick;

endmodule

// ### verification/ext_reset_model.sv
// Purpose: Board side of the reset pin, pull-up plus push button
// Assumes: Device pulls the pin low through an open-drain enable
// Notes:   Button hold time is set by the bench
`timescale 1ns/1ns
module ext_reset_model (
    input  wire logic pull_low_i,
    input  wire logic oe_i,
    output logic      pin_o
);
    // Wired-AND with pull-up, either party may hold it low
    assign pin_o = !(pull_low_i || oe_i);
endmodule

// ### verification/reset_state_chk.sv
// Purpose: Concurrent checks on the start state and restart sequence
// Assumes: One clock domain, srst_i synchronous active high
// Notes:   Start values are checked while cpu_reset_o is high
`timescale 1ns/1ns
module reset_state_chk (
    input wire logic                      mclk_i,
    input wire logic                      srst_i,
    input wire logic                      wdog_timeout_i,
    input wire logic                      watchdog_disable_bit_i,
    input wire logic                      reset_n_pin_oe_o,
    input wire logic                      cpu_reset_o,
    input wire logic [15:0]               fetch_addr_o,
    input wire logic                      fetch_valid_o,
    input wire rst_seq_pkg::ccr_flags_t   condition_code_register_o,
    input wire logic [7:0]                map_reg_o,
    input wire rst_seq_pkg::parallel_control_register_t        parallel_control_register_o,
    input wire logic [7:0]                port_b_out_o,
    input wire logic                      handshake_bus_o,
    input wire rst_seq_pkg::timer_init_t  timer_o,
    input wire rst_seq_pkg::serial_init_t serial_o,
    input wire rst_seq_pkg::misc_init_t   misc_o,
    input wire rst_seq_pkg::mode_bits_t   priority_register_o,
    input wire logic                      div_tick_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    // Vector burst: exactly three cycles, then dropped
    sequence fetch_burst;
        fetch_valid_o [*3] ##1 !fetch_valid_o;
    endsequence

    chk_ccr_masks: assert property (cpu_reset_o |->
        condition_code_register_o == 3'h7) else $error("ccr flags");
    chk_map_init: assert property (cpu_reset_o |->
        map_reg_o == 8'h01) else $error("map register");
    chk_parallel_control_register_init: assert property (cpu_reset_o |->
        parallel_control_register_o.strobe_edge_select &&
        (handshake_bus_o || parallel_control_register_o[4:1] == 4'h0))
        else $error("parallel control");
    chk_port_b: assert property (cpu_reset_o |->
        port_b_out_o == {8{handshake_bus_o}}) else $error("port b");
    chk_timer_init: assert property (cpu_reset_o |->
        timer_o == {16'h0000, 2'h0, 16'hffff, 8'h00, 3'h0, 8'h00, 9'h000})
        else $error("timer start");
    chk_serial_init: assert property (cpu_reset_o |->
        serial_o == 12'h830) else $error("serial start");
    chk_misc_init: assert property (cpu_reset_o |->
        !misc_o.periodic_flag && misc_o.periodic_rate == 2'h0 &&
        misc_o.watchdog_enable == !watchdog_disable_bit_i &&
        misc_o.watchdog_rate == 2'h0 && !misc_o.sync_port_enable)
        else $error("misc start");
    chk_ctrl_init: assert property (cpu_reset_o |->
        !misc_o.conv_done_flag && !misc_o.converter_power_up_bit &&
        !misc_o.eeprom_prog_enable && misc_o.priority_select == 4'h5 &&
        !misc_o.irq_edge_mode && misc_o.stop_recovery_delay_enable &&
        !misc_o.clock_watch_enable) else $error("control start");
    chk_fetch_len: assert property ($rose(fetch_valid_o) |->
        fetch_burst) else $error("fetch length");
    chk_vector_hi: assert property (fetch_valid_o |->
        fetch_addr_o[15:8] ==
        (priority_register_o.special_mode_bit ? 8'hbf : 8'hff))
        else $error("vector page");
    chk_cause_pin: assert property ($rose(wdog_timeout_i) |->
        ##[1:5] (reset_n_pin_oe_o && cpu_reset_o)) else $error("pin drive");
    chk_hold_seq: assert property ($fell(srst_i) |->
        cpu_reset_o && !fetch_valid_o) else $error("early release");
    chk_div_tick: assert property (div_tick_o |=>
        !div_tick_o [*3] ##1 div_tick_o) else $error("divider rate");
endmodule

bind reset_initial_state_control reset_state_chk u_chk (
    .mclk_i, .srst_i, .wdog_timeout_i, .watchdog_disable_bit_i,
    .reset_n_pin_oe_o, .cpu_reset_o, .fetch_addr_o, .fetch_valid_o,
    .condition_code_register_o, .map_reg_o, .parallel_control_register_o,
    .port_b_out_o, .handshake_bus_o, .timer_o, .serial_o, .misc_o,
    .priority_register_o, .div_tick_o
);

// ### verification/reset_initial_state_control_bench.sv
// Purpose: Self-checking bench for the reset start-state controller
// Assumes: 125 MHz clock, inputs driven by NBA on the rising edge
// Notes:   Start values are judged by the bound checker
`timescale 1ns/1ns
module reset_initial_state_control_bench;
    logic mclk_i, srst_i, ext_low, mode_a, mode_b, clkmon, wdog;
    logic rom_nv, ee_nv, wd_dis, pin, pin_oe, cpu_rst, fv, tick;
    logic rom_en, ee_en, start, pin_val;
    logic [7:0] pcd, pad, pao;
    logic [5:0] pdd;
    logic [15:0] addr;
    logic [7:0] pb;
    rst_seq_pkg::mode_bits_t prio;
    rst_seq_pkg::misc_init_t misc;
    int miscompares = 0;
    int total_checks = 0;

    ext_reset_model board (.pull_low_i(ext_low), .oe_i(pin_oe), .pin_o(pin));
    reset_initial_state_control dut (.mclk_i(mclk_i), .srst_i(srst_i),
        .reset_n_pin_i(pin), .mode_select_pin_a_i(mode_a),
        .mode_select_pin_b_i(mode_b), .clkmon_fail_i(clkmon),
        .wdog_timeout_i(wdog), .rom_enable_nv_i(rom_nv),
        .eeprom_enable_nv_i(ee_nv), .watchdog_disable_bit_i(wd_dis),
        .reset_n_pin_o(pin_val), .reset_n_pin_oe_o(pin_oe),
        .cpu_reset_o(cpu_rst),
        .fetch_addr_o(addr), .fetch_valid_o(fv), .cpu_start_o(start),
        .condition_code_register_o(), .map_reg_o(), .rom_enable_o(rom_en),
        .eeprom_enable_o(ee_en), .parallel_control_register_o(),
        .port_c_direction_register_o(pcd), .port_a_dir_o(pad),
        .port_a_out_o(pao), .port_b_out_o(pb), .port_d_dir_o(pdd),
        .handshake_bus_o(),
        .timer_o(), .serial_o(), .misc_o(misc),
        .priority_register_o(prio), .div_tick_o(tick));

    // Clock, free running
    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end

    task automatic check(input string what, input logic [15:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Sample 1 ns after the edge so register updates have landed
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask

    // Bounded wait for the vector fetch, then measure its length
    task automatic wait_fetch(input logic [15:0] vec);
        int n;
        int s;
        n = 0;
        s = 0;
        while (fv !== 1'b1 && n < 400) begin
            cyc(1);
            n++;
        end
        check("vector", addr, vec);
        n = 0;
        while (fv === 1'b1 && n < 9) begin
            cyc(1);
            n++;
            s += int'(start);
        end
        check("fetch length", n[15:0], 16'h0003);
        check("start pulse", s[15:0], 16'h0001);
    endtask

    task automatic t_mode(input logic b, a, input logic [3:0] bits);
        @(posedge mclk_i);
        srst_i <= 1'b1;
        mode_b <= b;
        mode_a <= a;
        wd_dis <= b;
        rom_nv <= a;
        ee_nv <= !a;
        cyc(8);
        check("port b", {8'h00, pb}, {8'h00, {8{a}}});
        check("tick in reset", {15'h0, tick}, 16'h0000);
        check("port dirs", {pcd, pad}, 16'h0078);
        check("port outs", {pao, 1'b0, pin_val, pdd}, 16'h0000);
        @(posedge mclk_i) srst_i <= 1'b0;
        wait_fetch({b ? 8'hff : 8'hbf, 8'hfe});
        check("mode bits", {12'h000, prio}, {12'h000, bits});
        check("watchdog", {15'h0, misc.watchdog_enable}, {15'h0, !b});
        check("nv copy", {14'h0, rom_en, ee_en}, {14'h0, a, !a});
    endtask

    task automatic t_cause(input logic w, c, input logic [15:0] vec);
        @(posedge mclk_i);
        wdog <= w;
        clkmon <= c;
        cyc(2);
        @(posedge mclk_i);
        wdog <= 1'b0;
        clkmon <= 1'b0;
        wait_fetch(vec);
    endtask

    task automatic t_pin();
        @(posedge mclk_i) ext_low <= 1'b1;
        cyc(20);
        check("pin held", {14'h0, pin, cpu_rst}, 16'h0001);
        check("no fetch", {15'h0, fv}, 16'h0000);
        @(posedge mclk_i) ext_low <= 1'b0;
        wait_fetch(16'hfffe);
    endtask

    task automatic t_div();
        int k;
        k = 0;
        repeat (8) begin
            cyc(1);
            k += int'(tick);
        end
        check("divider ticks", k[15:0], 16'h0002);
    endtask

    task automatic complete_run();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Watchdog, far beyond the expected run length
    initial begin
        #200000;
        miscompares++;
        complete_run();
    end

    // Main sequence; the last mode entered is single-chip
    initial begin
        srst_i = 1'b1;
        {ext_low, mode_a, mode_b, clkmon, wdog} = 5'h04;
        {rom_nv, ee_nv, wd_dis} = 3'h0;
        cyc(6);
        t_mode(1'b1, 1'b0, 4'h0);
        t_mode(1'b1, 1'b1, 4'h2);
        t_mode(1'b0, 1'b0, 4'hd);
        t_mode(1'b0, 1'b1, 4'h7);
        t_cause(1'b1, 1'b0, 16'hbffa);
        t_mode(1'b1, 1'b0, 4'h0);
        t_div();
        t_pin();
        t_cause(1'b0, 1'b1, 16'hfffc);
        t_cause(1'b1, 1'b1, 16'hfffa);
        complete_run();
    end
endmodule
